// >>> core/dsram_regs.svh
// Purpose: Constants shared by both ends of the burst SRAM link.
// Assumes: 32-bit APB on the controller, pclk at 100 MHz.
// Notes:   Offsets are byte addresses of aligned words.
//
// Overview of operation
// - Write: select low at K rise, two words.
// - Read: words at t+1 and t+2 output edges; the code uses t+1.5 and t+2 (PLL on), t+1 and t+1.5 (off).
// - Burst words go to address and address+1.
// - Power-up deselected, read outputs released.
// - Inputs on input clocks, outputs on output clocks.
// - Select zero low writes low lane only.
// - Select one low writes upper lane only.
// - All selects high: nothing stored.
// - Nine-bit width: one select gates word.
// - Each half applies its own mask.
// - Park clocks high when stopped, preferably.
// - PLL disabled: one cycle read latency.
// - Release outputs one edge after last word.
// - Read of fresh write returns newest data.
`ifndef DSRAM_REGS_SVH
`define DSRAM_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DSRAM_CTRL_OFS   8'h00
`define DSRAM_CMD_OFS    8'h04
`define DSRAM_WADDR_OFS  8'h08
`define DSRAM_RADDR_OFS  8'h0c
`define DSRAM_WD0_OFS    8'h10
`define DSRAM_WD1_OFS    8'h14
`define DSRAM_MASK_OFS   8'h18
`define DSRAM_RD0_OFS    8'h1c
`define DSRAM_RD1_OFS    8'h20
`define DSRAM_STAT_OFS   8'h24

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DSRAM_CTRL_PLL_BIT   0
`define DSRAM_CMD_WR_BIT     0
`define DSRAM_CMD_RD_BIT     1
`define DSRAM_STAT_BUSY_BIT  0
`define DSRAM_STAT_RDONE_BIT 1
`define DSRAM_MASK_H1_POS    8
`define DSRAM_CTRL_RST       1'b1
`define DSRAM_MASK_RST       16'h0000

// ----------------------------------------------------------------
// Lane width and timing
// ----------------------------------------------------------------
`define DSRAM_LANE_W     9
`define DSRAM_KHALF      8

`endif

// >>> core/dsram_pkg.sv
// Purpose: Types shared by both ends of the burst SRAM link.
// Assumes: Nothing beyond the constants header.
// Notes:   One-hot state codes.
package dsram_pkg;

  typedef enum logic [2:0]
  {
    DSRAM_O_IDLE = 3'b001,
    DSRAM_O_W1   = 3'b010,
    DSRAM_O_TAIL = 3'b100
  } dsram_oseq_t;

  typedef enum logic [3:0]
  {
    DSRAM_C_IDLE   = 4'b0001,
    DSRAM_C_LAUNCH = 4'b0010,
    DSRAM_C_DATA   = 4'b0100,
    DSRAM_C_RDWT   = 4'b1000
  } dsram_cstate_t;

endpackage

// >>> core/dsram_if.sv
// Purpose: Pins between the memory controller and the burst SRAM.
// Assumes: The controller makes all four link clocks.
// Notes:   Read data is released when q_oe_n is high.
`timescale 1ns/1ps
interface dsram_if #(
  parameter int DW  = 18,
  parameter int NBW = 2,
  parameter int AW  = 4
);
  logic           k;
  logic           k_n;
  logic           c;
  logic           c_n;
  logic           pll_disable_n;
  logic           read_port_select_n;
  logic           write_port_select_n;
  logic [AW-1:0]  addr;
  logic [NBW-1:0] byte_write_select_n;
  logic [DW-1:0]  d;
  logic [DW-1:0]  q;
  logic           q_oe_n;

  modport dev (
    input  k, k_n, c, c_n, pll_disable_n, read_port_select_n,
    input  write_port_select_n, addr, byte_write_select_n, d,
    output q, q_oe_n
  );

  modport ctl (
    output k, k_n, c, c_n, pll_disable_n, read_port_select_n,
    output write_port_select_n, addr, byte_write_select_n, d,
    input  q, q_oe_n
  );
endinterface

// >>> core/dsram_dev.sv
// Purpose: Burst SRAM end: command decode, masked writes, DDR reads.
// Assumes: Link pins are asynchronous to pclk and are synchronised.
// Notes:   Storage is a flip-flop array of 2**(AW+1) words.
`timescale 1ns/1ps
`include "dsram_regs.svh"
module dsram_dev #(
  parameter int DW  = 18,
  parameter int NBW = 2,
  parameter int AW  = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  dsram_if.dev      link,
  output logic      wr_commit_ff
);
  import dsram_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int LW = `DSRAM_LANE_W;
  localparam int SW = 7 + AW + NBW + DW;
  // Pins leave reset at their idle levels, so no false clock edge follows.
  localparam logic [SW-1:0] PIN_IDLE = {4'ha, 3'h7, {AW{1'b0}}, {NBW{1'b1}}, {DW{1'b0}}};

  logic [SW-1:0]  s1_ff;
  logic [SW-1:0]  s2_ff;
  logic [3:0]     clk_d_ff;
  logic [3:0]     rise;
  logic           s_k;
  logic           s_kn;
  logic           s_c;
  logic           s_cn;
  logic           s_pll;
  logic           s_rsl_n;
  logic           s_wsl_n;
  logic [AW-1:0]  s_addr;
  logic [NBW-1:0] s_bsl_n;
  logic [DW-1:0]  s_d;

  wire [SW-1:0] pins = {link.k, link.k_n, link.c, link.c_n,
                        link.pll_disable_n, link.read_port_select_n,
                        link.write_port_select_n, link.addr,
                        link.byte_write_select_n, link.d};

  // All pins share one two-stage path, so their skew is preserved.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff    <= PIN_IDLE;
      s2_ff    <= PIN_IDLE;
      clk_d_ff <= 4'hf;
    end
    else
    begin
      s1_ff    <= pins;
      s2_ff    <= s1_ff;
      clk_d_ff <= s2_ff[SW-1 -: 4];
    end
  end

  assign {s_k, s_kn, s_c, s_cn, s_pll, s_rsl_n, s_wsl_n,
          s_addr, s_bsl_n, s_d} = s2_ff;

  // Rising edge of each link clock: k, k_n, c, c_n.
  // No edge means no activity, so stopped clocks hold everything.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_edge
      assign rise[gi] = s2_ff[SW-4+gi] & ~clk_d_ff[gi];
    end
  endgenerate

  wire k_rise  = rise[3];
  wire kn_rise = rise[2];
  wire c_rise  = rise[1];
  wire cn_rise = rise[0];

  // ----------------------------------------------------------------
  // Byte-lane merge
  // ----------------------------------------------------------------
  // A low select replaces its lane; a high select keeps the old lane.
  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0]  old_w,
    input logic [DW-1:0]  new_w,
    input logic [NBW-1:0] bn
  );
    lane_merge = old_w;
    for (int i = 0; i < NBW; i++)
    begin
      if (!bn[i])
      begin
        lane_merge[i*LW +: LW] = new_w[i*LW +: LW];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  logic [DW-1:0]  mem [2**(AW+1)];
  logic           wpend_ff;
  logic [DW-1:0]  wd0_ff;
  logic [NBW-1:0] wm0_ff;

  wire wr_start = k_rise & ~s_wsl_n;
  wire commit   = kn_rise & wpend_ff;
  wire [AW:0] widx0 = {s_addr, 1'b0};
  wire [AW:0] widx1 = {s_addr, 1'b1};

  // First word and its mask are held until the second half arrives.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wpend_ff     <= 1'b0;
      wd0_ff       <= '0;
      wm0_ff       <= '1;
      wr_commit_ff <= 1'b0;
    end
    else
    begin
      wr_commit_ff <= commit;
      if (wr_start)
      begin
        wpend_ff <= 1'b1;
        wd0_ff   <= s_d;
        wm0_ff   <= s_bsl_n;
      end
      else if (commit)
      begin
        wpend_ff <= 1'b0;
      end
    end
  end

  // Data storage carries no reset; contents are undefined at power-up.
  always_ff @(posedge pclk)
  begin
    if (commit)
    begin
      mem[widx0] <= lane_merge(mem[widx0], wd0_ff, wm0_ff);
      mem[widx1] <= lane_merge(mem[widx1], s_d, s_bsl_n);
    end
  end

  // ----------------------------------------------------------------
  // Read port: address capture and fetch
  // ----------------------------------------------------------------
  logic           rpend_ff;
  logic [AW-1:0]  raddr_ff;
  logic [AW-1:0]  ob_addr_ff;
  logic [DW-1:0]  obuf0_ff;
  logic [DW-1:0]  obuf1_ff;
  logic           armed_ff;

  // The fetch happens one K rise after the read was taken.
  wire fetch = k_rise & rpend_ff;
  wire pll   = s_pll;
  wire [DW-1:0] f0 = mem[{raddr_ff, 1'b0}];
  wire [DW-1:0] f1 = mem[{raddr_ff, 1'b1}];

  // A write that commits while words wait to leave updates them.
  wire hit = commit & (s_addr == ob_addr_ff);
  wire [DW-1:0] fw0 = hit ? lane_merge(obuf0_ff, wd0_ff, wm0_ff)
                          : obuf0_ff;
  wire [DW-1:0] fw1 = hit ? lane_merge(obuf1_ff, s_d, s_bsl_n)
                          : obuf1_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rpend_ff   <= 1'b0;
      raddr_ff   <= '0;
      ob_addr_ff <= '0;
      obuf0_ff   <= '0;
      obuf1_ff   <= '0;
    end
    else
    begin
      if (k_rise)
      begin
        rpend_ff <= ~s_rsl_n;
        raddr_ff <= s_addr;
      end
      if (fetch)
      begin
        ob_addr_ff <= raddr_ff;
        obuf0_ff   <= f0;
        obuf1_ff   <= f1;
      end
      else if (hit)
      begin
        obuf0_ff <= fw0;
        obuf1_ff <= fw1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port: output sequencer
  // ----------------------------------------------------------------
  // With the PLL on, word 0 leaves on c_n and word 1 on c; with it
  // off the order shifts half a cycle earlier.
  dsram_oseq_t    ost_ff;
  dsram_oseq_t    nxt_ost;
  logic [DW-1:0]  q_ff;
  logic [DW-1:0]  nxt_q;
  logic           oe_n_ff;
  logic           nxt_oe_n;

  wire ea = pll ? cn_rise : c_rise;
  wire eb = pll ? c_rise : cn_rise;
  wire start_now = ea & (armed_ff | (fetch & ~pll));
  wire [DW-1:0] w0val = armed_ff ? fw0 : f0;

  always_comb
  begin
    nxt_ost  = ost_ff;
    nxt_q    = q_ff;
    nxt_oe_n = oe_n_ff;
    if (start_now)
    begin
      nxt_ost  = DSRAM_O_W1;
      nxt_q    = w0val;
      nxt_oe_n = 1'b0;
    end
    else
    begin
      unique case (ost_ff)
        DSRAM_O_IDLE:
        begin
          nxt_oe_n = 1'b1;
        end
        DSRAM_O_W1:
        begin
          if (eb)
          begin
            nxt_ost = DSRAM_O_TAIL;
            nxt_q   = fw1;
          end
        end
        DSRAM_O_TAIL:
        begin
          if (ea)
          begin
            nxt_ost  = DSRAM_O_IDLE;
            nxt_oe_n = 1'b1;
          end
        end
        default:
        begin
          nxt_ost  = DSRAM_O_IDLE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Outputs come up released and the sequencer idle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ost_ff   <= DSRAM_O_IDLE;
      q_ff     <= '0;
      oe_n_ff  <= 1'b1;
      armed_ff <= 1'b0;
    end
    else
    begin
      ost_ff   <= nxt_ost;
      q_ff     <= nxt_q;
      oe_n_ff  <= nxt_oe_n;
      armed_ff <= (fetch & pll) | (armed_ff & ~ea);
    end
  end

  assign link.q      = q_ff;
  assign link.q_oe_n = oe_n_ff;

endmodule // dsram_dev

// >>> core/dsram_ctl.sv
// Purpose: Memory controller end: makes link clocks, runs bursts.
// Assumes: Software drives it over APB; pclk at 100 MHz.
// Notes:   One burst at a time; KHALF of at least 8 leaves margin.
`timescale 1ns/1ps
`include "dsram_regs.svh"
module dsram_ctl #(
  parameter int DW    = 18,
  parameter int NBW   = 2,
  parameter int AW    = 4,
  parameter int KHALF = `DSRAM_KHALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  dsram_if.ctl             link
);
  import dsram_pkg::*;

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  localparam int PW = $clog2(2*KHALF);
  localparam logic [PW-1:0] PH_LAST = PW'(2*KHALF-1);
  localparam logic [PW-1:0] PH_PREK = PW'(KHALF + KHALF/2);
  localparam logic [PW-1:0] PH_PRKN = PW'(KHALF/2);
  localparam logic [PW-1:0] PH_MID  = PW'(KHALF-1);

  logic [PW-1:0] ph_ff;
  logic          k_ff;
  wire  [PW-1:0] nxt_ph = (ph_ff == PH_LAST) ? '0 : ph_ff + 1'b1;

  // Clocks idle high in reset, the preferred parking level.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_ff <= '0;
      k_ff  <= 1'b1;
    end
    else
    begin
      ph_ff <= nxt_ph;
      k_ff  <= (nxt_ph < PW'(KHALF));
    end
  end

  // c follows k so the device's two edge sets line up.
  assign link.k   = k_ff;
  assign link.k_n = ~k_ff;
  assign link.c   = k_ff;
  assign link.c_n = ~k_ff;

  wire pre_k  = ph_ff == PH_PREK;
  wire pre_kn = ph_ff == PH_PRKN;
  wire smp    = (ph_ff == PH_LAST) | (ph_ff == PH_MID);

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic           pll_en_ff;
  logic [AW-1:0]  waddr_ff;
  logic [AW-1:0]  raddr_ff;
  logic [DW-1:0]  wd0_ff;
  logic [DW-1:0]  wd1_ff;
  logic [15:0]    mask_ff;
  logic [DW-1:0]  rd0_ff;
  logic [DW-1:0]  rd1_ff;
  logic           rdone_ff;
  logic           go_wr_ff;
  logic           go_rd_ff;
  dsram_cstate_t  st_ff;

  wire busy   = st_ff != DSRAM_C_IDLE;
  wire wr_acc = psel & penable & pwrite;
  wire sel_ct = paddr == `DSRAM_CTRL_OFS;
  wire sel_cm = paddr == `DSRAM_CMD_OFS;
  wire sel_wa = paddr == `DSRAM_WADDR_OFS;
  wire sel_ra = paddr == `DSRAM_RADDR_OFS;
  wire sel_w0 = paddr == `DSRAM_WD0_OFS;
  wire sel_w1 = paddr == `DSRAM_WD1_OFS;
  wire sel_mk = paddr == `DSRAM_MASK_OFS;
  wire sel_r0 = paddr == `DSRAM_RD0_OFS;
  wire sel_r1 = paddr == `DSRAM_RD1_OFS;
  wire sel_st = paddr == `DSRAM_STAT_OFS;
  wire mapped = sel_ct | sel_cm | sel_wa | sel_ra | sel_w0 | sel_w1 |
                sel_mk | sel_r0 | sel_r1 | sel_st;
  wire cmd_ok = wr_acc & sel_cm & ~busy;
  wire cmd_rd = cmd_ok & pwdata[`DSRAM_CMD_RD_BIT];
  wire rd_fin;

  wire [31:0] rd_mux =
      sel_ct ? {31'h0, pll_en_ff} :
      sel_wa ? 32'(waddr_ff) :
      sel_ra ? 32'(raddr_ff) :
      sel_w0 ? 32'(wd0_ff) :
      sel_w1 ? 32'(wd1_ff) :
      sel_mk ? {16'h0, mask_ff} :
      sel_r0 ? 32'(rd0_ff) :
      sel_r1 ? 32'(rd1_ff) :
      sel_st ? {30'h0, rdone_ff, busy} : 32'h0;

  // Read data is registered in setup so the access phase needs no wait.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata    <= 32'h0;
      pll_en_ff <= `DSRAM_CTRL_RST;
      waddr_ff  <= '0;
      raddr_ff  <= '0;
      wd0_ff    <= '0;
      wd1_ff    <= '0;
      mask_ff   <= `DSRAM_MASK_RST;
      rdone_ff  <= 1'b0;
    end
    else
    begin
      if (psel & ~penable)
        prdata <= rd_mux;
      if (wr_acc & sel_ct)
        pll_en_ff <= pwdata[`DSRAM_CTRL_PLL_BIT];
      if (wr_acc & sel_wa)
        waddr_ff <= pwdata[AW-1:0];
      if (wr_acc & sel_ra)
        raddr_ff <= pwdata[AW-1:0];
      if (wr_acc & sel_w0)
        wd0_ff <= pwdata[DW-1:0];
      if (wr_acc & sel_w1)
        wd1_ff <= pwdata[DW-1:0];
      if (wr_acc & sel_mk)
        mask_ff <= pwdata[15:0];
      // A completing read wins over the clear from a new command.
      rdone_ff <= rd_fin | (rdone_ff & ~cmd_rd);
    end
  end

  assign link.pll_disable_n = pll_en_ff;

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  logic [DW-1:0]  q1_ff;
  logic [DW-1:0]  q2_ff;
  logic [2:0]     scnt_ff;
  logic           rsl_n_ff;
  logic           wsl_n_ff;
  logic [AW-1:0]  addr_ff;
  logic [NBW-1:0] bsl_n_ff;
  logic [DW-1:0]  d_ff;

  // Sample counts where read words are stable after the device's
  // synchroniser and output register delays.
  wire [2:0] n_w0 = pll_en_ff ? 3'h3 : 3'h2;
  wire [2:0] n_w1 = pll_en_ff ? 3'h4 : 3'h3;
  assign rd_fin = (st_ff == DSRAM_C_RDWT) & smp & (scnt_ff == n_w1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff    <= DSRAM_C_IDLE;
      go_wr_ff <= 1'b0;
      go_rd_ff <= 1'b0;
      scnt_ff  <= 3'h0;
      rsl_n_ff <= 1'b1;
      wsl_n_ff <= 1'b1;
      addr_ff  <= '0;
      bsl_n_ff <= '1;
      d_ff     <= '0;
      q1_ff    <= '0;
      q2_ff    <= '0;
      rd0_ff   <= '0;
      rd1_ff   <= '0;
    end
    else
    begin
      q1_ff <= link.q;
      q2_ff <= q1_ff;
      unique case (st_ff)
        DSRAM_C_IDLE:
        begin
          if (cmd_ok & (pwdata[1:0] != 2'b00))
          begin
            go_wr_ff <= pwdata[`DSRAM_CMD_WR_BIT];
            go_rd_ff <= pwdata[`DSRAM_CMD_RD_BIT];
            st_ff    <= DSRAM_C_LAUNCH;
          end
        end
        DSRAM_C_LAUNCH:
        begin
          if (pre_k)
          begin
            rsl_n_ff <= ~go_rd_ff;
            wsl_n_ff <= ~go_wr_ff;
            addr_ff  <= raddr_ff;
            d_ff     <= wd0_ff;
            bsl_n_ff <= mask_ff[NBW-1:0];
            st_ff    <= DSRAM_C_DATA;
          end
        end
        DSRAM_C_DATA:
        begin
          if (pre_kn)
          begin
            rsl_n_ff <= 1'b1;
            wsl_n_ff <= 1'b1;
            addr_ff  <= waddr_ff;
            d_ff     <= wd1_ff;
            bsl_n_ff <= mask_ff[`DSRAM_MASK_H1_POS +: NBW];
            scnt_ff  <= 3'h0;
            st_ff    <= go_rd_ff ? DSRAM_C_RDWT : DSRAM_C_IDLE;
          end
        end
        DSRAM_C_RDWT:
        begin
          if (smp)
          begin
            scnt_ff <= scnt_ff + 3'h1;
            if (scnt_ff == n_w0)
              rd0_ff <= q2_ff;
            if (rd_fin)
            begin
              rd1_ff <= q2_ff;
              st_ff  <= DSRAM_C_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign link.read_port_select_n  = rsl_n_ff;
  assign link.write_port_select_n = wsl_n_ff;
  assign link.addr                = addr_ff;
  assign link.byte_write_select_n = bsl_n_ff;
  assign link.d                   = d_ff;

endmodule // dsram_ctl

// >>> bench/dsram_link_checker.sv
// Purpose: Concurrent checks on the burst SRAM link pins.
// Assumes: KHALF of 8, so one K period is 16 pclk.
// Notes:   Windows allow for the device's two-flop synchronisers.
`timescale 1ns/1ps
module dsram_link_checker #(
  parameter int DW  = 18,
  parameter int NBW = 2,
  parameter int AW  = 4
) (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           k,
  input wire logic           k_n,
  input wire logic           c,
  input wire logic           c_n,
  input wire logic           pll_disable_n,
  input wire logic           read_port_select_n,
  input wire logic           write_port_select_n,
  input wire logic [AW-1:0]  addr,
  input wire logic [NBW-1:0] byte_write_select_n,
  input wire logic [DW-1:0]  d,
  input wire logic [DW-1:0]  q,
  input wire logic           q_oe_n,
  input wire logic           wr_commit_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------
  // Ages since the last starts
  // --------
  logic       k_q_ff;
  logic [7:0] rd_age_ff;
  logic [7:0] wr_age_ff;
  logic [7:0] nxt_rd_age;
  logic [7:0] nxt_wr_age;
  wire        k_rise = k & ~k_q_ff;

  // Ages saturate so that a long idle time never wraps back into a window.
  assign nxt_rd_age = (k_rise && !read_port_select_n) ? 8'h00 :
                      (rd_age_ff == 8'hff) ? 8'hff : rd_age_ff + 8'h01;
  assign nxt_wr_age = (k_rise && !write_port_select_n) ? 8'h00 :
                      (wr_age_ff == 8'hff) ? 8'hff : wr_age_ff + 8'h01;

  // Helper registers start as if nothing was ever requested.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      k_q_ff    <= 1'b1;
      rd_age_ff <= 8'hff;
      wr_age_ff <= 8'hff;
    end
    else
    begin
      k_q_ff    <= k;
      rd_age_ff <= nxt_rd_age;
      wr_age_ff <= nxt_wr_age;
    end
  end

  // --------
  // Properties
  // --------
  sequence s_rd_on;
    $rose(k) && !read_port_select_n && pll_disable_n;
  endsequence
  sequence s_rd_off;
    $rose(k) && !read_port_select_n && !pll_disable_n;
  endsequence
  sequence s_wr;
    $rose(k) && !write_port_select_n;
  endsequence

  property p_clk_pair;
    (k_n == ~k) && (c == k) && (c_n == k_n);
  endproperty
  property p_sel_hold;
    ($rose(k) || $rose(k_n)) |-> $stable(read_port_select_n) && $stable(write_port_select_n)
      && $stable(addr) && $stable(d) && $stable(byte_write_select_n);
  endproperty
  property p_rd_lat_on;
    s_rd_on |-> ##22 q_oe_n ##[1:10] !q_oe_n;
  endproperty
  property p_rd_lat_off;
    s_rd_off |-> ##12 q_oe_n ##[1:12] !q_oe_n;
  endproperty
  property p_release;
    $fell(q_oe_n) |-> (!q_oe_n)[*8] ##[8:12] q_oe_n;
  endproperty
  property p_wr_land;
    s_wr |-> ##[8:18] wr_commit_ff;
  endproperty
  property p_commit_cause;
    wr_commit_ff |-> wr_age_ff inside {[8'h06:8'h14]};
  endproperty
  property p_oe_cause;
    !q_oe_n |-> rd_age_ff inside {[8'h0c:8'h38]};
  endproperty

  a_clk_pair: assert property (p_clk_pair)
    else $error("link clocks out of phase");
  a_sel_hold: assert property (p_sel_hold)
    else $error("link inputs moved at a clock rise");
  a_rd_lat_on: assert property (p_rd_lat_on)
    else $error("read latency wrong with PLL on");
  a_rd_lat_off: assert property (p_rd_lat_off)
    else $error("read latency wrong with PLL off");
  a_release: assert property (p_release)
    else $error("read outputs not released on time");
  a_wr_land: assert property (p_wr_land)
    else $error("write burst did not land");
  a_commit_cause: assert property (p_commit_cause)
    else $error("write landed without a write start");
  a_oe_cause: assert property (p_oe_cause)
    else $error("read outputs driven without a read");
endmodule // dsram_link_checker

// >>> bench/test_ddr_sep_port_sram_access.sv
// Purpose: Self-checking bench for both ends of the burst SRAM link.
// Assumes: KHALF of 8; software reaches the controller over APB.
// Notes:   Data is judged in the low 18 bits of the read registers.
`timescale 1ns/1ps
`include "dsram_regs.svh"
module test_ddr_sep_port_sram_access;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wr_commit;
  logic [31:0] rd_data;
  logic        rd_err;
  int          bad_count;
  int          samples_checked;

  dsram_if i_dsram_if ();
  dsram_ctl i_dsram_ctl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(i_dsram_if.ctl));
  dsram_dev i_dsram_dev (.pclk(pclk), .presetn(presetn),
    .link(i_dsram_if.dev), .wr_commit_ff(wr_commit));
  dsram_link_checker i_dsram_link_checker (.pclk(pclk),
    .presetn(presetn), .k(i_dsram_if.k), .k_n(i_dsram_if.k_n), .c(i_dsram_if.c),
    .c_n(i_dsram_if.c_n), .pll_disable_n(i_dsram_if.pll_disable_n),
    .read_port_select_n(i_dsram_if.read_port_select_n),
    .write_port_select_n(i_dsram_if.write_port_select_n), .addr(i_dsram_if.addr),
    .byte_write_select_n(i_dsram_if.byte_write_select_n), .d(i_dsram_if.d),
    .q(i_dsram_if.q), .q_oe_n(i_dsram_if.q_oe_n), .wr_commit_ff(wr_commit));

  // --------
  // Shared tasks
  // --------
  task automatic summarize();
    $display("Checks made %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20)
    begin
      bad_count++;
      $display("[ERR] %0t APB answer timed out", $time);
      summarize();
    end
  endtask

  // Polls status until idle; a read also waits for its done flag.
  task automatic wait_done(input logic want_rd);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `DSRAM_STAT_OFS, 32'h0);
      n++;
    end
    while ((rd_data[`DSRAM_STAT_BUSY_BIT] !== 1'b0 ||
            (want_rd && rd_data[`DSRAM_STAT_RDONE_BIT] !== 1'b1)) && n < 100);
    if (n >= 100)
    begin
      bad_count++;
      $display("[ERR] %0t burst never finished", $time);
      summarize();
    end
  endtask

  task automatic set_up(input logic [3:0] a, input logic [17:0] w0, input logic [17:0] w1,
                        input logic [15:0] m);
    apb(1'b1, `DSRAM_WADDR_OFS, {28'h0, a});
    apb(1'b1, `DSRAM_RADDR_OFS, {28'h0, a});
    apb(1'b1, `DSRAM_WD0_OFS, {14'h0, w0});
    apb(1'b1, `DSRAM_WD1_OFS, {14'h0, w1});
    apb(1'b1, `DSRAM_MASK_OFS, {16'h0, m});
  endtask

  // Runs one burst with the given command bits; a read burst also checks both read words.
  task automatic run(input logic [31:0] cmd, input logic [17:0] e0, input logic [17:0] e1);
    apb(1'b1, `DSRAM_CMD_OFS, cmd);
    wait_done(cmd[`DSRAM_CMD_RD_BIT]);
    if (cmd[`DSRAM_CMD_RD_BIT])
    begin
      apb(1'b0, `DSRAM_RD0_OFS, 32'h0);
      chk({14'h0, rd_data[17:0]}, {14'h0, e0}, "first word");
      apb(1'b0, `DSRAM_RD1_OFS, 32'h0);
      chk({14'h0, rd_data[17:0]}, {14'h0, e1}, "second word");
    end
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_power_up();
    chk({31'h0, i_dsram_if.q_oe_n}, 32'h1, "outputs released");
    apb(1'b0, `DSRAM_CTRL_OFS, 32'h0);
    chk({31'h0, rd_data[0]}, {31'h0, `DSRAM_CTRL_RST}, "ctrl reset");
    apb(1'b0, `DSRAM_MASK_OFS, 32'h0);
    chk({16'h0, rd_data[15:0]}, {16'h0, `DSRAM_MASK_RST}, "mask reset");
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, rd_err}, 32'h1, "unmapped error");
    chk(rd_data, 32'h0, "unmapped data");
    $display("Test power-up done");
  endtask

  task automatic t_basic(input logic pll, input logic [3:0] a, input logic [17:0] w);
    apb(1'b1, `DSRAM_CTRL_OFS, {31'h0, pll});
    set_up(a, w, ~w, 16'h0000);
    run(32'h1, 18'h0, 18'h0);
    run(32'h2, w, ~w);
    $display("Test basic burst done, pll %0d", pll);
  endtask

  task automatic t_mask();
    apb(1'b1, `DSRAM_CTRL_OFS, 32'h1);
    set_up(4'h5, 18'h2aaaa, 18'h15555, 16'h0000);
    run(32'h1, 18'h0, 18'h0);
    set_up(4'h5, 18'h00000, 18'h00000, 16'h0102);
    run(32'h3, 18'h2aa00, 18'h00155);
    set_up(4'h5, 18'h3ffff, 18'h3ffff, 16'h0003);
    run(32'h1, 18'h0, 18'h0);
    run(32'h2, 18'h2aa00, 18'h3ffff);
    $display("Test byte masks done");
  endtask

  task automatic t_nop_forward();
    int i;
    for (i = 0; i < 64; i++)
    begin
      @(posedge pclk);
      chk({31'h0, i_dsram_if.q_oe_n}, 32'h1, "idle outputs");
    end
    set_up(4'h3, 18'h01234, 18'h04321, 16'h0000);
    run(32'h1, 18'h0, 18'h0);
    set_up(4'h3, 18'h3c3c3, 18'h0f0f0, 16'h0000);
    run(32'h3, 18'h3c3c3, 18'h0f0f0);
    $display("Test idle and forwarding done");
  endtask

  // --------
  // Clock, watchdog and main sequence
  // --------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // A hang anywhere ends the run through the same closing report.
  initial
  begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    $display("[ERR] %0t run timed out", $time);
    summarize();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_power_up();
    t_basic(1'b1, 4'h0, 18'h1a5c3);
    t_basic(1'b0, 4'hf, 18'h2c0de);
    t_mask();
    t_nop_forward();
    summarize();
  end
endmodule // test_ddr_sep_port_sram_access
